// >>> core/prl_defs.vh
// register offsets, field positions, key values and reset values of the remap lock
`ifndef PRL_DEFS_VH
`define PRL_DEFS_VH

// register byte offsets on the avalon slave (one aligned word each)
`define PRL_OFF_OSC       8'h00
`define PRL_OFF_STAT      8'h04
`define PRL_OFF_ICLR      8'h08
`define PRL_OFF_IEN       8'h0C
`define PRL_OFF_INFO      8'h10
`define PRL_OFF_MAP       8'h40

// map window decode: offsets 0x40..0x7C
`define PRL_MAP_SEL_HI    7
`define PRL_MAP_SEL_LO    6
`define PRL_MAP_SEL_VAL   2'h1

// unlock keys written to the low byte of the oscillator control register
`define PRL_KEY1          8'h46
`define PRL_KEY2          8'h57

// field positions
`define PRL_LOCK_BIT      6
`define PRL_FUSE_BIT      5
`define PRL_INFO_ONEWAY   0
`define PRL_INFO_ARMED    1
`define PRL_INFO_MISMATCH 2

// event bits shared by status, clear and enable registers
`define PRL_EV_W          4
`define PRL_EV_BLOCKED    0
`define PRL_EV_LOCKCHG    1
`define PRL_EV_REFUSED    2
`define PRL_EV_MISMATCH   3

// reset values
`define PRL_LOCK_RST      1'b0
`define PRL_FUSE_RST      1'b1
`define PRL_IEN_RST       4'h0
`define PRL_STAT_RST      4'h0

`endif

// >>> core/prl_map_mem.v
// storage cells of the peripheral input and output map registers
`timescale 1ns/1ps
module prl_map_mem #(
    parameter N  = 16,
    parameter W  = 8,
    parameter AW = 4
) (
    // clock, reset, enable
    input  wire             clk,
    input  wire             rst,
    input  wire             ce,
    // write port
    input  wire             wr_en,
    input  wire [AW-1:0]    wr_idx,
    input  wire [W-1:0]     wr_data,
    // read port, data one edge after the index
    input  wire [AW-1:0]    rd_idx,
    output reg  [W-1:0]     rd_data_r,
    // cell disturbance injection, xor into the cells
    input  wire [N*W-1:0]   upset,
    // all cells side by side
    output wire [N*W-1:0]   cells
);

    reg [W-1:0] cell_r [0:N-1];

    // one cell per entry; an upset models a corrupted storage cell
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_cell
            // entry index at the width of the write index
            localparam [AW-1:0] IDX = i;
            always @(posedge clk) begin
                if (rst) begin
                    cell_r[i] <= {W{1'b0}};
                end else if (ce) begin
                    if (wr_en && (wr_idx == IDX)) begin
                        cell_r[i] <= wr_data;
                    end else begin
                        cell_r[i] <= cell_r[i] ^ upset[i*W +: W];
                    end
                end
            end
            assign cells[i*W +: W] = cell_r[i];
        end
    endgenerate

    // registered read
    always @(posedge clk) begin
        if (rst) begin
            rd_data_r <= {W{1'b0}};
        end else if (ce) begin
            rd_data_r <= cell_r[rd_idx];
        end
    end

endmodule // prl_map_mem

// >>> core/prl_shadow_cmp.v
// shadow copies of the map registers and their continuous comparison
`timescale 1ns/1ps
module prl_shadow_cmp #(
    parameter N  = 16,
    parameter W  = 8,
    parameter AW = 4
) (
    // clock, reset, enable
    input  wire             clk,
    input  wire             rst,
    input  wire             ce,
    // permitted writes, mirrored into the shadow
    input  wire             wr_en,
    input  wire [AW-1:0]    wr_idx,
    input  wire [W-1:0]     wr_data,
    // live cells under watch
    input  wire [N*W-1:0]   cells,
    // sticky mismatch, cleared only by reset
    output reg              mismatch_r
);

    wire [N-1:0] diff;

    // shadow follows only permitted writes, so any other change shows as a diff
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_shadow
            // entry index at the width of the write index
            localparam [AW-1:0] IDX = i;
            reg [W-1:0] shadow_r;
            always @(posedge clk) begin
                if (rst) begin
                    shadow_r <= {W{1'b0}};
                end else if (ce && wr_en && (wr_idx == IDX)) begin
                    shadow_r <= wr_data;
                end
            end
            assign diff[i] = (shadow_r != cells[i*W +: W]);
        end
    endgenerate

    // compare every cycle
    always @(posedge clk) begin
        if (rst) begin
            mismatch_r <= 1'b0;
        end else if (ce && (|diff)) begin
            mismatch_r <= 1'b1;
        end
    end

endmodule // prl_shadow_cmp

// >>> core/prl_remap_lock.v
// write lock, key sequence and shadow check of the peripheral pin remap registers
//
// Functional notes
// - While the lock is set, writes to input and output map registers leave them unchanged.
// - A blocked map write completes like any other write, without error or extra stall.
// - The remap lock bit sits at bit 6 of the oscillator control register.
// - Lock one refuses map writes, lock zero accepts and stores them.
// - The lock changes only on the write that follows keys 0x46 then 0x57 to bits 7:0.
// - The lock holds its value until the next keyed change and never relocks by itself.
// - Shadow copies watch the map registers and a stray change raises a mismatch reset.
// - With the one-session fuse (config bit 5) set, a set lock cannot be cleared.
// - In one-session mode with the lock set, the key sequence does nothing.
// - In one-session mode only a device reset returns the lock to zero.
// - The fuse reads as set when unprogrammed; programmed to zero it allows any sessions.
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "prl_defs.vh"
module prl_remap_lock #(
    parameter N_IN  = 8,
    parameter N_OUT = 8,
    parameter MAP_W = 8,
    parameter AW    = 4
) (
    // clock, reset, enable
    input  wire                           sys_clk,
    input  wire                           rst,
    input  wire                           ce,
    // avalon-mm slave
    input  wire [7:0]                     avs_address,
    input  wire                           avs_read,
    input  wire                           avs_write,
    input  wire [31:0]                    avs_writedata,
    output reg  [31:0]                    avs_readdata,
    output reg                            avs_waitrequest,
    // oscillator configuration word from the fuse array
    input  wire [7:0]                     osc_cfg_word,
    // cell disturbance injection for the map cells
    input  wire [(N_IN+N_OUT)*MAP_W-1:0]  map_upset,
    // map contents to the pin multiplexer, inputs first
    output wire [(N_IN+N_OUT)*MAP_W-1:0]  map_cells,
    // lock state and reset request
    output reg                            remap_lock_bit,
    output reg                            cfg_mismatch_rst,
    // interrupt
    output reg                            irq
);

    // entries 0..N_IN-1 are input maps, the rest output maps
    // the map index is taken straight from address bits 5:2, so N must not exceed 16
    localparam N = N_IN + N_OUT;

    // bus states
    localparam B_IDLE  = 3'b001;
    localparam B_FETCH = 3'b010;
    localparam B_ANS   = 3'b100;

    // key sequence states
    localparam K_IDLE  = 3'b001;
    localparam K_ONE   = 3'b010;
    localparam K_ARMED = 3'b100;

    reg  [2:0]               bus_st_r;
    reg  [2:0]               key_st_r;
    reg                      fuse_s1_r;
    reg                      fuse_s2_r;
    reg  [`PRL_EV_W-1:0]     stat_r;
    reg  [`PRL_EV_W-1:0]     ien_r;
    reg                      mis_d_r;
    reg  [`PRL_EV_W-1:0]     ev_set;
    reg  [2:0]               key_st_nxt;
    reg                      lock_nxt;
    reg  [31:0]              rdata_nxt;

    wire                     one_way;
    wire                     wr_fire;
    wire                     osc_hit;
    wire                     map_hit;
    wire [AW-1:0]            map_idx;
    wire [7:0]               wbyte;
    wire                     map_wr_ok;
    wire [MAP_W-1:0]         map_rdata;
    wire                     mismatch;
    wire [`PRL_EV_W-1:0]     clr_mask;
    wire [`PRL_EV_W-1:0]     stat_nxt;

    // fuse bit from another domain, two flops; reset value is the erased state
    always @(posedge sys_clk) begin
        if (rst) begin
            fuse_s1_r <= `PRL_FUSE_RST;
            fuse_s2_r <= `PRL_FUSE_RST;
        end else if (ce) begin
            fuse_s1_r <= osc_cfg_word[`PRL_FUSE_BIT];
            fuse_s2_r <= fuse_s1_r;
        end
    end

    assign one_way = fuse_s2_r;

    // a write is taken once, on the edge where the master sees waitrequest low
    // taking it any earlier would let a master that aborts its request still
    // change the lock or a map cell; the answer edge is the one both sides agree on
    // the key sequence therefore advances only on completed transfers
    assign wr_fire = ce && (bus_st_r == B_ANS) && avs_write;
    assign wbyte   = avs_writedata[7:0];
    assign osc_hit = (avs_address == `PRL_OFF_OSC);
    assign map_hit = (avs_address[`PRL_MAP_SEL_HI:`PRL_MAP_SEL_LO] == `PRL_MAP_SEL_VAL)
                     && (avs_address[5:2] < N);
    assign map_idx = avs_address[5:2];

    // map writes pass only while unlocked
    assign map_wr_ok = wr_fire && map_hit && !remap_lock_bit;

    // bus handshake: two wait cycles, then one answer cycle
    // the fixed latency keeps blocked and accepted writes indistinguishable
    // on the bus; the only trace of a refusal is a status bit
    // read data are latched in the fetch state, so the registered map read
    // port has had a full cycle to follow the address
    always @(posedge sys_clk) begin
        if (rst) begin
            bus_st_r        <= B_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else if (ce) begin
            case (bus_st_r)
                B_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_st_r <= B_FETCH;
                    end
                end
                // blocked writes answer like any write
                B_FETCH: begin
                    bus_st_r        <= B_ANS;
                    avs_waitrequest <= 1'b0;
                    avs_readdata    <= avs_read ? rdata_nxt : 32'h00000000;
                end
                B_ANS: begin
                    bus_st_r        <= B_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_st_r        <= B_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // read data selection, unmapped offsets read zero
    always @* begin
        rdata_nxt = 32'h00000000;
        if (osc_hit) begin
            rdata_nxt[`PRL_LOCK_BIT] = remap_lock_bit;
        end else if (avs_address == `PRL_OFF_STAT) begin
            rdata_nxt[`PRL_EV_W-1:0] = stat_r;
        end else if (avs_address == `PRL_OFF_IEN) begin
            rdata_nxt[`PRL_EV_W-1:0] = ien_r;
        end else if (avs_address == `PRL_OFF_INFO) begin
            rdata_nxt[`PRL_INFO_ONEWAY]   = one_way;
            rdata_nxt[`PRL_INFO_ARMED]    = (key_st_r == K_ARMED);
            rdata_nxt[`PRL_INFO_MISMATCH] = mismatch;
        end else if (map_hit) begin
            rdata_nxt[MAP_W-1:0] = map_rdata;
        end
    end

    // key sequence and lock update
    // every completed write restarts the sequence unless it is the next key,
    // so a stray write between the keys costs a full restart
    // limitation: the sequence is only tracked per bus, not per master
    always @* begin
        key_st_nxt = key_st_r;
        lock_nxt   = remap_lock_bit;
        ev_set     = {`PRL_EV_W{1'b0}};
        if (wr_fire) begin
            key_st_nxt = K_IDLE;
            if (map_hit && remap_lock_bit) begin
                ev_set[`PRL_EV_BLOCKED] = 1'b1;
            end
            if (osc_hit) begin
                case (key_st_r)
                    K_IDLE: begin
                        // keys ignored once a one-session lock is set
                        if ((wbyte == `PRL_KEY1) && !(one_way && remap_lock_bit)) begin
                            key_st_nxt = K_ONE;
                        end else if (wbyte[`PRL_LOCK_BIT] != remap_lock_bit) begin
                            ev_set[`PRL_EV_REFUSED] = 1'b1;
                        end
                    end
                    K_ONE: begin
                        if (wbyte == `PRL_KEY2) begin
                            key_st_nxt = K_ARMED;
                        end else if (wbyte == `PRL_KEY1) begin
                            key_st_nxt = K_ONE;
                        end else if (wbyte[`PRL_LOCK_BIT] != remap_lock_bit) begin
                            ev_set[`PRL_EV_REFUSED] = 1'b1;
                        end
                    end
                    // the single write after both keys
                    K_ARMED: begin
                        if (one_way && remap_lock_bit && !wbyte[`PRL_LOCK_BIT]) begin
                            ev_set[`PRL_EV_REFUSED] = 1'b1;
                        end else begin
                            lock_nxt = wbyte[`PRL_LOCK_BIT];
                            ev_set[`PRL_EV_LOCKCHG] = (wbyte[`PRL_LOCK_BIT] != remap_lock_bit);
                        end
                    end
                    default: begin
                        key_st_nxt = K_IDLE;
                    end
                endcase
            end
        end
        ev_set[`PRL_EV_MISMATCH] = mismatch && !mis_d_r;
    end

    // lock and key state; the lock never moves on its own
    always @(posedge sys_clk) begin
        if (rst) begin
            // only reset clears a one-session lock
            key_st_r       <= K_IDLE;
            remap_lock_bit <= `PRL_LOCK_RST;
        end else if (ce) begin
            key_st_r       <= key_st_nxt;
            // held until the next keyed write
            remap_lock_bit <= lock_nxt;
        end
    end

    // map storage, index taken from the bus address
    prl_map_mem #(
        .N  (N),
        .W  (MAP_W),
        .AW (AW)
    ) u_mem (
        .clk       (sys_clk),
        .rst       (rst),
        .ce        (ce),
        .wr_en     (map_wr_ok),
        .wr_idx    (map_idx),
        .wr_data   (avs_writedata[MAP_W-1:0]),
        .rd_idx    (map_idx),
        .rd_data_r (map_rdata),
        .upset     (map_upset),
        .cells     (map_cells)
    );

    prl_shadow_cmp #(
        .N  (N),
        .W  (MAP_W),
        .AW (AW)
    ) u_shadow (
        .clk        (sys_clk),
        .rst        (rst),
        .ce         (ce),
        .wr_en      (map_wr_ok),
        .wr_idx     (map_idx),
        .wr_data    (avs_writedata[MAP_W-1:0]),
        .cells      (map_cells),
        .mismatch_r (mismatch)
    );

    // one-cycle reset request on the rising mismatch
    always @(posedge sys_clk) begin
        if (rst) begin
            mis_d_r          <= 1'b0;
            cfg_mismatch_rst <= 1'b0;
        end else if (ce) begin
            mis_d_r          <= mismatch;
            cfg_mismatch_rst <= mismatch && !mis_d_r;
        end
    end

    // write-one-to-clear; a new event in the same cycle wins over the clear
    // losing an event is worse than one spurious extra interrupt
    assign clr_mask = (wr_fire && (avs_address == `PRL_OFF_ICLR)) ?
                      avs_writedata[`PRL_EV_W-1:0] : {`PRL_EV_W{1'b0}};
    assign stat_nxt = (stat_r & ~clr_mask) | ev_set;

    // status, enable and the level interrupt
    always @(posedge sys_clk) begin
        if (rst) begin
            stat_r <= `PRL_STAT_RST;
            ien_r  <= `PRL_IEN_RST;
            irq    <= 1'b0;
        end else if (ce) begin
            stat_r <= stat_nxt;
            if (wr_fire && (avs_address == `PRL_OFF_IEN)) begin
                ien_r <= avs_writedata[`PRL_EV_W-1:0];
            end
            irq <= |(stat_r & ien_r);
        end
    end

endmodule // prl_remap_lock

// >>> tb/prl_remap_lock_properties.sv
// concurrent checks of the remap lock block, bound to its top module
`timescale 1ns/1ps
module prl_lock_chk #(
    parameter N_IN  = 8,
    parameter N_OUT = 8,
    parameter MAP_W = 8
) (
    // clock and reset
    input wire                          sys_clk,
    input wire                          rst,
    // avalon-mm slave
    input wire [7:0]                    avs_address,
    input wire                          avs_read,
    input wire                          avs_write,
    input wire [31:0]                   avs_writedata,
    input wire [31:0]                   avs_readdata,
    input wire                          avs_waitrequest,
    // fuse word, injection, map and status outputs
    input wire [7:0]                    osc_cfg_word,
    input wire [(N_IN+N_OUT)*MAP_W-1:0] map_upset,
    input wire [(N_IN+N_OUT)*MAP_W-1:0] map_cells,
    input wire                          remap_lock_bit,
    input wire                          cfg_mismatch_rst,
    input wire                          irq
);
    // helper levels, kept as wires so $past sees plain signals
    wire req    = avs_read | avs_write;
    wire osc_wr = avs_write & (avs_address == 8'h00);
    wire upset  = |map_upset;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    answer_delay_a: assert property (
        $rose(req) |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
        else $error("answer not on second edge after request");
    wait_pulse_a: assert property (
        $fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    lock_read_a: assert property (
        avs_read && !avs_waitrequest && avs_address == 8'h00
        |-> avs_readdata == {25'h0, remap_lock_bit, 6'h0})
        else $error("lock bit not read back at bit 6");
    lock_cause_a: assert property (
        $changed(remap_lock_bit) |-> $past(osc_wr))
        else $error("lock changed without a control write");
    map_frozen_a: assert property (
        remap_lock_bit && !upset |=> $stable(map_cells))
        else $error("map contents changed while locked");
    map_store_a: assert property (
        avs_write && !avs_waitrequest && avs_address[7:6] == 2'h1 && !remap_lock_bit && !upset
        |=> map_cells[$past(avs_address[5:2])*MAP_W +: MAP_W]
            == $past(avs_writedata[MAP_W-1:0]))
        else $error("unlocked map write not stored");
    mismatch_cause_a: assert property (
        cfg_mismatch_rst |-> $past(upset, 3))
        else $error("mismatch request without a disturbed cell");
    mismatch_pulse_a: assert property (
        cfg_mismatch_rst |=> !cfg_mismatch_rst)
        else $error("mismatch request wider than one cycle");
    oneway_hold_a: assert property (
        $fell(remap_lock_bit) |-> !osc_cfg_word[5])
        else $error("lock cleared in one-session mode");

    // main scenarios reached
    cover property ($rose(remap_lock_bit));
    cover property (cfg_mismatch_rst);
    cover property ($rose(irq));
endmodule // prl_lock_chk

bind prl_remap_lock prl_lock_chk #(.N_IN(N_IN), .N_OUT(N_OUT), .MAP_W(MAP_W)) prl_lock_chk_inst (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .osc_cfg_word(osc_cfg_word), .map_upset(map_upset),
    .map_cells(map_cells), .remap_lock_bit(remap_lock_bit),
    .cfg_mismatch_rst(cfg_mismatch_rst), .irq(irq));

// >>> tb/prl_remap_lock_bench.sv
// self-checking bench of the remap lock block
`timescale 1ns/1ps
`include "prl_defs.vh"
module prl_remap_lock_bench;
    // stimulus and observed outputs
    reg          sys_clk       = 1'b0;
    reg          rst           = 1'b1;
    reg  [7:0]   avs_address   = 8'h00;
    reg          avs_read      = 1'b0;
    reg          avs_write     = 1'b0;
    reg  [31:0]  avs_writedata = 32'h0;
    reg  [7:0]   osc_cfg_word  = 8'h00;
    reg  [127:0] map_upset     = 128'h0;
    wire [31:0]  avs_readdata;
    wire         avs_waitrequest;
    wire [127:0] map_cells;
    wire         remap_lock_bit;
    wire         cfg_mismatch_rst;
    wire         irq;
    // bookkeeping and map model
    integer      err_total = 0;
    integer      checked   = 0;
    integer      seed      = 32'hF7A5;
    integer      i;
    integer      n;
    reg  [7:0]   mv [0:15];
    reg  [31:0]  exp_q [$];

    prl_remap_lock prl_remap_lock_inst (
        .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .osc_cfg_word(osc_cfg_word), .map_upset(map_upset), .map_cells(map_cells),
        .remap_lock_bit(remap_lock_bit), .cfg_mismatch_rst(cfg_mismatch_rst), .irq(irq));

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", checked, err_total);
            if (err_total == 0 && checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    task cmp_rd(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("ERROR t=%0t read %h expected %h", $time, got, exp);
            end
        end
    endtask

    task cmp_pin(input got, input exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("ERROR t=%0t pin %h expected %h", $time, got, exp);
            end
        end
    endtask

    // one transfer; held until waitrequest is sampled low, bounded wait
    task bus(input wr_sel, input [7:0] a, input [31:0] d);
        begin
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr_sel;
            avs_read <= !wr_sel;
            n = 0;
            @(posedge sys_clk);
            while (avs_waitrequest !== 1'b0) begin
                n = n + 1;
                if (n > 40) begin
                    err_total = err_total + 1;
                    give_verdict;
                end
                @(posedge sys_clk);
            end
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            // one idle edge so the next request is never assigned twice in a step
            @(posedge sys_clk);
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        bus(1'b1, a, d);
    endtask

    // expectation is queued first, the monitor pairs it with the answer
    task rd(input [7:0] a, input [31:0] e);
        begin
            exp_q.push_back(e);
            bus(1'b0, a, 32'h0);
        end
    endtask

    task key(input [7:0] v);
        begin
            wr(`PRL_OFF_OSC, {24'h0, `PRL_KEY1});
            wr(`PRL_OFF_OSC, {24'h0, `PRL_KEY2});
            wr(`PRL_OFF_OSC, {24'h0, v});
        end
    endtask

    // random full word; only the low byte is expected to land
    task wmap(input integer k, input ok);
        reg [31:0] d;
        begin
            d = $random(seed);
            wr(`PRL_OFF_MAP + k * 4, d);
            if (ok)
                mv[k] = d[7:0];
        end
    endtask

    task chk_maps;
        for (i = 0; i < 16; i = i + 1)
            rd(`PRL_OFF_MAP + i * 4, {24'h0, mv[i]});
    endtask

    task do_reset;
        begin
            rst <= 1'b1;
            repeat (2) @(posedge sys_clk);
            rst <= 1'b0;
            // fuse synchroniser settles two edges after release
            repeat (3) @(posedge sys_clk);
            for (i = 0; i < 16; i = i + 1)
                mv[i] = 8'h00;
        end
    endtask

    // read results against the oldest queued expectation
    always @(posedge sys_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            if (exp_q.size() > 0)
                cmp_rd(avs_readdata, exp_q.pop_front());
            else
                err_total = err_total + 1;
        end
    end

    // main sequence: unlimited-session fuse first, one-session fuse last
    initial begin
        do_reset;
        rd(`PRL_OFF_OSC, 32'h0);
        rd(`PRL_OFF_INFO, 32'h0);
        wr(8'h20, 32'hFF);
        rd(8'h20, 32'h0);
        rd(`PRL_OFF_ICLR, 32'h0);
        for (i = 0; i < 16; i = i + 1)
            wmap(i, 1'b1);
        chk_maps;
        wr(`PRL_OFF_ICLR, 32'hF);
        key(8'h40);
        cmp_pin(remap_lock_bit, 1'b1);
        rd(`PRL_OFF_OSC, 32'h40);
        rd(`PRL_OFF_STAT, 32'h2);
        wr(`PRL_OFF_ICLR, 32'hF);
        wmap(3, 1'b0);
        chk_maps;
        rd(`PRL_OFF_STAT, 32'h1);
        // clear without keys, then keys broken by another write
        wr(`PRL_OFF_ICLR, 32'hF);
        wr(`PRL_OFF_OSC, 32'h0);
        rd(`PRL_OFF_STAT, 32'h4);
        wr(`PRL_OFF_OSC, 32'h46);
        wr(`PRL_OFF_IEN, 32'h0);
        wr(`PRL_OFF_OSC, 32'h57);
        wr(`PRL_OFF_OSC, 32'h0);
        cmp_pin(remap_lock_bit, 1'b1);
        // one unlock, many map writes, lock stays open
        key(8'h00);
        for (i = 0; i < 16; i = i + 1)
            wmap(i, 1'b1);
        chk_maps;
        cmp_pin(remap_lock_bit, 1'b0);
        // interrupt masked, raised, cleared
        wr(`PRL_OFF_ICLR, 32'hF);
        wr(`PRL_OFF_IEN, 32'h9);
        rd(`PRL_OFF_IEN, 32'h9);
        key(8'h40);
        repeat (2) @(posedge sys_clk);
        cmp_pin(irq, 1'b0);
        wmap(5, 1'b0);
        repeat (2) @(posedge sys_clk);
        cmp_pin(irq, 1'b1);
        wr(`PRL_OFF_ICLR, 32'h1);
        repeat (2) @(posedge sys_clk);
        cmp_pin(irq, 1'b0);
        // one disturbed cell bit in output map entry 10
        map_upset <= 128'h1 << 84;
        mv[10] = mv[10] ^ 8'h10;
        @(posedge sys_clk);
        map_upset <= 128'h0;
        repeat (2) @(posedge sys_clk);
        #1 cmp_pin(cfg_mismatch_rst, 1'b1);
        repeat (2) @(posedge sys_clk);
        cmp_pin(irq, 1'b1);
        rd(`PRL_OFF_STAT, 32'hA);
        rd(`PRL_OFF_INFO, 32'h4);
        chk_maps;
        // one-session fuse: lock sticks until reset
        osc_cfg_word <= 8'h20;
        do_reset;
        rd(`PRL_OFF_INFO, 32'h1);
        key(8'h40);
        key(8'h00);
        cmp_pin(remap_lock_bit, 1'b1);
        wmap(7, 1'b0);
        chk_maps;
        do_reset;
        cmp_pin(remap_lock_bit, 1'b0);
        wmap(7, 1'b1);
        chk_maps;
        give_verdict;
    end
endmodule // prl_remap_lock_bench
